/* File: rtl/mode_ctl.sv */
// Control-mode supervision, open-loop current and standstill reduction
//
// Functional notes
// R1: After successful auto setup copy results and request drive and tuning store.
// R2: Master treats coordinates invalid after auto setup and restarts device.
// R3: Velocity test run: mode 2, target speed, then enable operation.
// R4: An all-zero control word stops driving the motor.
// R5: Master reads status after each transfer to confirm acceptance; the master model reads status only at chosen checks.
// R6: Open loop exists for steppers only; brushless runs closed loop.
// R7: Physical and model-based feedback may be combined.
// R8: Torque modes never run while open loop is selected.
// R9: Homing-on-block methods are refused in open loop.
// R10: Master avoids cyclic position or velocity modes in open loop.
// R11: Open loop drives the configured maximum current at every speed; the code cuts to the reduction value at standstill (R13).
// R12: Master clears the loop-select bit to choose open loop.
// R13: Standstill cut bit enables current reduction in open loop.
// R14: Reduction starts only after the programmed idle milliseconds.
// R15: While reduced, current falls to the programmed reduction value.
// R16: Master programs pole pairs from the step angle.
// R17: Master writes maximum current in milliamperes.
// R18: Clock-direction pulses are scaled by multiplier over divider.
// R19: Selected mode takes effect on entering operation enabled; shown separately.
// R20: Mode changes accepted only outside operation enabled.
// R21: Motion restarts idle timer and restores full current at once.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module mode_ctl #(
  parameter int unsigned CYC_PER_MS = motor_ctl_pkg::CYC_PER_MS
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire motor_ctl_pkg::bus_req_s bus_in,
  output logic [31:0] rdata_out,
  input wire motor_ctl_pkg::setup_s setup_in,
  input wire logic motion_pin_in,
  input wire logic step_pin_in,
  input wire logic dir_pin_in,
  output motor_ctl_pkg::drive_s drive_out,
  output logic [1:0] store_out,
  output logic step_out
);

  motor_ctl_pkg::ctl_state_s st;
  motor_ctl_pkg::ctl_state_s next_st;
  logic step_edge;
  logic motion;
  logic open_loop;
  logic torque_mode;
  logic home_block;
  logic reduce_now;
  logic ms_tick;
  logic [15:0] cw;
  logic [31:0] status;

  // ----------------------------------------
  // Derived conditions
  // ----------------------------------------
  assign step_edge = st.sync2[1] & ~st.step_prev;
  assign motion = st.sync2[0] | step_edge;
  // Loop select is ignored for brushless motors
  assign open_loop = ~st.submode[motor_ctl_pkg::SUB_LOOP_BIT]
                   & ~st.submode[motor_ctl_pkg::SUB_BLDC_BIT]; // see R6
  assign torque_mode = (st.mode_act == motor_ctl_pkg::MODE_TORQUE)
                     | (st.mode_act == motor_ctl_pkg::MODE_CST);
  assign home_block = (st.mode_act == motor_ctl_pkg::MODE_HOMING)
                    & (st.home_meth >= motor_ctl_pkg::HOME_BLOCK_LO); // see R9
  assign ms_tick = (st.ms_div == 20'(CYC_PER_MS - 1));
  assign reduce_now = open_loop & st.submode[motor_ctl_pkg::SUB_CUT_BIT]
                    & ~motion & (st.idle_ms >= st.idle_set); // see R13
  assign cw = bus_in.wdata[15:0];

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_comb
  begin
    status = 32'h0000_0000;
    unique case (st.pwr)
      motor_ctl_pkg::PWR_DISABLED: status[6:0] = 7'h40;
      motor_ctl_pkg::PWR_READY: status[6:0] = 7'h21;
      motor_ctl_pkg::PWR_ON: status[6:0] = 7'h23;
      motor_ctl_pkg::PWR_OPEN: status[6:0] = 7'h27;
    endcase
    status[motor_ctl_pkg::ST_FAULT_BIT] = st.drive.mode_fault;
    status[motor_ctl_pkg::ST_RED_BIT] = st.reduced;
    status[motor_ctl_pkg::ST_COORD_BIT] = st.coord_bad;
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.sync1 = {dir_pin_in, step_pin_in, motion_pin_in};
    next_st.sync2 = st.sync1;
    next_st.step_prev = st.sync2[1];
    next_st.store = 2'b00;

    // Register writes
    if (bus_in.wr)
    begin
      unique case (bus_in.addr)
        motor_ctl_pkg::OFS_POLES: next_st.poles = bus_in.wdata[7:0];
        motor_ctl_pkg::OFS_IMAX: next_st.imax = bus_in.wdata[15:0];
        motor_ctl_pkg::OFS_IDLE_MS: next_st.idle_set = bus_in.wdata[15:0];
        motor_ctl_pkg::OFS_RED_MA: next_st.red_ma = bus_in.wdata[15:0];
        motor_ctl_pkg::OFS_CD_MUL: next_st.cd_mul = bus_in.wdata[15:0];
        motor_ctl_pkg::OFS_CD_DIV: next_st.cd_div = bus_in.wdata[15:0];
        motor_ctl_pkg::OFS_FB_CFG: next_st.fb_cfg = bus_in.wdata[1:0];
        motor_ctl_pkg::OFS_SUBMODE: next_st.submode = bus_in.wdata;
        motor_ctl_pkg::OFS_TGT_VEL: next_st.tgt_vel = bus_in.wdata;
        motor_ctl_pkg::OFS_HOME_METH: next_st.home_meth = bus_in.wdata[7:0];
        motor_ctl_pkg::OFS_MODE_SEL:
        begin
          // A running drive keeps its selection
          if (st.pwr != motor_ctl_pkg::PWR_OPEN)
            next_st.mode_sel = bus_in.wdata[7:0]; // see R20
        end
        motor_ctl_pkg::OFS_CTRL:
        begin
          next_st.ctrl = cw;
          if (cw == 16'h0000 || !cw[motor_ctl_pkg::CW_EV])
            next_st.pwr = motor_ctl_pkg::PWR_DISABLED; // see R4
          else if (!cw[motor_ctl_pkg::CW_QS])
            next_st.pwr = motor_ctl_pkg::PWR_DISABLED;
          else if (!cw[motor_ctl_pkg::CW_SO])
            next_st.pwr = motor_ctl_pkg::PWR_READY;
          else if (!cw[motor_ctl_pkg::CW_EO])
          begin
            if (st.pwr != motor_ctl_pkg::PWR_DISABLED)
              next_st.pwr = motor_ctl_pkg::PWR_ON;
          end
          else if (st.pwr == motor_ctl_pkg::PWR_ON
                   || st.pwr == motor_ctl_pkg::PWR_OPEN)
            next_st.pwr = motor_ctl_pkg::PWR_OPEN;
        end
        default: next_st.ctrl = st.ctrl;
      endcase
    end

    // Selected mode becomes the running mode only on entry
    if (next_st.pwr == motor_ctl_pkg::PWR_OPEN && st.pwr != motor_ctl_pkg::PWR_OPEN)
      next_st.mode_act = st.mode_sel; // see R19

    // Auto setup results win over a same-cycle register write
    if (setup_in.done && setup_in.ok)
    begin
      next_st.poles = setup_in.poles; // see R1
      next_st.res_r = setup_in.res_r;
      next_st.res_l = setup_in.res_l;
      next_st.store = 2'b11; // see R1
      // Stays set until restart, homing does not clear it
      next_st.coord_bad = 1'b1; // see R2
    end

    // Standstill idle timer in milliseconds
    next_st.ms_div = ms_tick ? 20'h00000 : st.ms_div + 20'h00001;
    if (motion)
    begin
      next_st.ms_div = 20'h00000; // see R21
      next_st.idle_ms = 16'h0000; // see R21
    end
    else if (ms_tick && st.idle_ms != 16'hffff)
      next_st.idle_ms = st.idle_ms + 16'h0001; // see R14
    next_st.reduced = reduce_now; // see R15

    // Read data stands for exactly the cycle after the strobe
    next_st.rdata = 32'h0000_0000;
    if (bus_in.rd)
    begin
      unique case (bus_in.addr)
        motor_ctl_pkg::OFS_STORE: next_st.rdata = {30'h0, st.coord_bad, st.coord_bad};
        motor_ctl_pkg::OFS_POLES: next_st.rdata = {24'h0, st.poles};
        motor_ctl_pkg::OFS_IMAX: next_st.rdata = {16'h0, st.imax};
        motor_ctl_pkg::OFS_IDLE_MS: next_st.rdata = {16'h0, st.idle_set};
        motor_ctl_pkg::OFS_RED_MA: next_st.rdata = {16'h0, st.red_ma};
        motor_ctl_pkg::OFS_CD_MUL: next_st.rdata = {16'h0, st.cd_mul};
        motor_ctl_pkg::OFS_CD_DIV: next_st.rdata = {16'h0, st.cd_div};
        motor_ctl_pkg::OFS_FB_CFG: next_st.rdata = {30'h0, st.fb_cfg};
        motor_ctl_pkg::OFS_RES_R: next_st.rdata = st.res_r;
        motor_ctl_pkg::OFS_RES_L: next_st.rdata = st.res_l;
        motor_ctl_pkg::OFS_SUBMODE: next_st.rdata = st.submode;
        motor_ctl_pkg::OFS_CTRL: next_st.rdata = {16'h0, st.ctrl};
        motor_ctl_pkg::OFS_STAT: next_st.rdata = status;
        motor_ctl_pkg::OFS_TGT_VEL: next_st.rdata = st.tgt_vel;
        motor_ctl_pkg::OFS_MODE_SEL: next_st.rdata = {24'h0, st.mode_sel};
        motor_ctl_pkg::OFS_MODE_ACT: next_st.rdata = {24'h0, st.mode_act};
        motor_ctl_pkg::OFS_HOME_METH: next_st.rdata = {24'h0, st.home_meth};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // ----------------------------------------
    // Drive outputs
    // ----------------------------------------
    next_st.drive.open_loop = open_loop;
    next_st.drive.mode_fault = open_loop & (torque_mode | home_block); // see R8
    next_st.drive.enable = (st.pwr == motor_ctl_pkg::PWR_OPEN)
                         & ~next_st.drive.mode_fault; // see R8
    next_st.drive.homing_ok = ~(open_loop & home_block); // see R9
    next_st.drive.fb_phys = st.fb_cfg[0]; // see R7
    next_st.drive.fb_model = st.fb_cfg[1]; // see R7
    next_st.drive.reduced = reduce_now;
    // Open loop ignores load, so full current is applied except during standstill reduction
    next_st.drive.cur_ma = reduce_now ? st.red_ma : st.imax; // see R11
    next_st.drive.mode_act = st.mode_act; // see R19
    next_st.drive.dir = st.sync2[2];
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st <= '0;
      st.pwr <= motor_ctl_pkg::PWR_DISABLED;
      st.submode <= motor_ctl_pkg::RST_SUBMODE;
      st.poles <= motor_ctl_pkg::RST_POLES;
      st.imax <= motor_ctl_pkg::RST_IMAX;
      st.idle_set <= motor_ctl_pkg::RST_IDLE_MS;
      st.red_ma <= motor_ctl_pkg::RST_RED_MA;
      st.cd_mul <= motor_ctl_pkg::RST_CD_RATIO;
      st.cd_div <= motor_ctl_pkg::RST_CD_RATIO;
      st.drive.homing_ok <= 1'b1;
    end
    else if (ce_in)
      st <= next_st;
  end

  // ----------------------------------------
  // Clock-direction scaling
  // ----------------------------------------
  cd_step_scaler u_scaler (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .pulse_in(step_edge),
    .mul_in(st.cd_mul),
    .div_in(st.cd_div),
    .step_out(step_out)
  );

  assign rdata_out = st.rdata;
  assign drive_out = st.drive;
  assign store_out = st.store;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  AST_ZERO_CW_STOPS: // see R4
    assert property (ce_in && bus_in.wr && bus_in.addr == motor_ctl_pkg::OFS_CTRL
                     && bus_in.wdata == 32'h0 ##1 ce_in |=> !drive_out.enable)
      else $error("zero control word did not stop the drive");

  AST_MODE_LOCKED: // see R20
    assert property (ce_in && bus_in.wr && bus_in.addr == motor_ctl_pkg::OFS_MODE_SEL
                     && st.pwr == motor_ctl_pkg::PWR_OPEN
                     |=> st.mode_sel == $past(st.mode_sel))
      else $error("mode changed while operation enabled");

  AST_MODE_ON_ENTRY: // see R19
    assert property ($rose(st.pwr == motor_ctl_pkg::PWR_OPEN)
                     |-> st.mode_act == $past(st.mode_sel))
      else $error("running mode not taken on entry");

  AST_NO_TORQUE_OPEN: // see R8
    assert property (drive_out.enable && drive_out.open_loop
                     |-> drive_out.mode_act != motor_ctl_pkg::MODE_TORQUE
                         && drive_out.mode_act != motor_ctl_pkg::MODE_CST)
      else $error("torque mode running in open loop");

  AST_BLDC_CLOSED: // see R6
    assert property (ce_in && st.submode[motor_ctl_pkg::SUB_BLDC_BIT]
                     |=> !drive_out.open_loop)
      else $error("open loop with brushless motor");

  AST_REDUCED_CURRENT: // see R15
    assert property (ce_in && reduce_now |=> drive_out.reduced
                     && drive_out.cur_ma == $past(st.red_ma))
      else $error("reduced current not applied");

  AST_MOTION_FULL: // see R21
    assert property (ce_in && motion |=> !drive_out.reduced
                     && drive_out.cur_ma == $past(st.imax))
      else $error("full current not restored on motion");

  AST_IDLE_WAIT: // see R14
    assert property ($rose(st.reduced) |-> $past(st.idle_ms) >= $past(st.idle_set))
      else $error("reduction before idle time elapsed");

  AST_SETUP_STORE: // see R1
    assert property (ce_in && setup_in.done && setup_in.ok
                     |=> store_out == 2'b11 && st.res_r == $past(setup_in.res_r))
      else $error("auto setup results not stored");

  // Drive outputs lag the state by one cycle, so these look one edge later
  AST_STORE_PULSE: // see R1
    assert property (ce_in && !(setup_in.done && setup_in.ok)
                     |=> store_out == 2'b00)
      else $error("store request without completed auto setup");

  AST_FULL_CURRENT: // see R11
    assert property (ce_in && !reduce_now
                     |=> drive_out.cur_ma == $past(st.imax))
      else $error("set current differs from maximum current");

  AST_CUT_NEEDS_BIT: // see R13
    assert property (ce_in && !st.submode[motor_ctl_pkg::SUB_CUT_BIT]
                     |=> !drive_out.reduced)
      else $error("current reduced with standstill cut disabled");

  AST_BLOCK_HOMING_OFF: // see R9
    assert property (ce_in && open_loop && home_block
                     |=> !drive_out.homing_ok && !drive_out.enable)
      else $error("homing on block offered in open loop");

  AST_ACT_HELD: // see R19
    assert property (st.pwr == motor_ctl_pkg::PWR_OPEN
                     |=> st.mode_act == $past(st.mode_act))
      else $error("running mode changed during operation");

  AST_FB_COMBINED: // see R7
    assert property (ce_in |=> drive_out.fb_phys == $past(st.fb_cfg[0])
                     && drive_out.fb_model == $past(st.fb_cfg[1]))
      else $error("feedback sources not passed through");

  AST_ZERO_CW_DISABLES: // see R4
    assert property (ce_in && bus_in.wr && bus_in.addr == motor_ctl_pkg::OFS_CTRL
                     && bus_in.wdata == 32'h0000_0000
                     |=> st.pwr == motor_ctl_pkg::PWR_DISABLED)
      else $error("zero control word did not disable the power stage");

  AST_RDATA_IDLE:
    assert property (ce_in && !bus_in.rd |=> rdata_out == 32'h0000_0000)
      else $error("read data stood outside its cycle");

endmodule : mode_ctl

/* File: rtl/motor_ctl_pkg.sv */
// Shared constants, types and register map of the control-mode block
package motor_ctl_pkg;

  // ----------------------------------------
  // Register offsets (object indices)
  // ----------------------------------------
  localparam logic [15:0] OFS_STORE = 16'h1010;
  localparam logic [15:0] OFS_POLES = 16'h2030;
  localparam logic [15:0] OFS_IMAX = 16'h2031;
  localparam logic [15:0] OFS_IDLE_MS = 16'h2036;
  localparam logic [15:0] OFS_RED_MA = 16'h2037;
  localparam logic [15:0] OFS_CD_MUL = 16'h2057;
  localparam logic [15:0] OFS_CD_DIV = 16'h2058;
  localparam logic [15:0] OFS_FB_CFG = 16'h2f00;
  localparam logic [15:0] OFS_RES_R = 16'h2f01;
  localparam logic [15:0] OFS_RES_L = 16'h2f02;
  localparam logic [15:0] OFS_SUBMODE = 16'h3202;
  localparam logic [15:0] OFS_CTRL = 16'h6040;
  localparam logic [15:0] OFS_STAT = 16'h6041;
  localparam logic [15:0] OFS_TGT_VEL = 16'h6042;
  localparam logic [15:0] OFS_MODE_SEL = 16'h6060;
  localparam logic [15:0] OFS_MODE_ACT = 16'h6061;
  localparam logic [15:0] OFS_HOME_METH = 16'h6098;

  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int SUB_LOOP_BIT = 0;
  localparam int SUB_CUT_BIT = 3;
  localparam int SUB_BLDC_BIT = 6;
  localparam int CW_SO = 0;
  localparam int CW_EV = 1;
  localparam int CW_QS = 2;
  localparam int CW_EO = 3;
  localparam int ST_FAULT_BIT = 8;
  localparam int ST_RED_BIT = 9;
  localparam int ST_COORD_BIT = 14;
  localparam logic [7:0] MODE_TORQUE = 8'h04;
  localparam logic [7:0] MODE_CST = 8'h0a;
  localparam logic [7:0] MODE_HOMING = 8'h06;
  // Homing-on-block methods are the negative codes -1 .. -4
  localparam logic [7:0] HOME_BLOCK_LO = 8'hfc;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] RST_SUBMODE = 32'h0000_0000;
  localparam logic [7:0] RST_POLES = 8'h32;
  localparam logic [15:0] RST_IMAX = 16'h01f4;
  localparam logic [15:0] RST_IDLE_MS = 16'h03e8;
  localparam logic [15:0] RST_RED_MA = 16'h00fa;
  localparam logic [15:0] RST_CD_RATIO = 16'h0001;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {PWR_DISABLED, PWR_READY, PWR_ON, PWR_OPEN} pwr_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic done;
    logic ok;
    logic [7:0] poles;
    logic [31:0] res_r;
    logic [31:0] res_l;
  } setup_s;

  typedef struct packed {
    logic enable;
    logic open_loop;
    logic reduced;
    logic fb_phys;
    logic fb_model;
    logic homing_ok;
    logic mode_fault;
    logic dir;
    logic [15:0] cur_ma;
    logic [7:0] mode_act;
  } drive_s;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic step_prev;
    pwr_e pwr;
    logic [15:0] ctrl;
    logic [7:0] mode_sel;
    logic [7:0] mode_act;
    logic [31:0] tgt_vel;
    logic [31:0] submode;
    logic [7:0] poles;
    logic [15:0] imax;
    logic [15:0] idle_set;
    logic [15:0] red_ma;
    logic [15:0] cd_mul;
    logic [15:0] cd_div;
    logic [7:0] home_meth;
    logic [1:0] fb_cfg;
    logic [31:0] res_r;
    logic [31:0] res_l;
    logic coord_bad;
    logic [19:0] ms_div;
    logic [15:0] idle_ms;
    logic reduced;
    logic [31:0] rdata;
    logic [1:0] store;
    drive_s drive;
  } ctl_state_s;

  typedef struct packed {
    logic [16:0] acc;
    logic step;
  } cd_state_s;

endpackage : motor_ctl_pkg

/* File: rtl/cd_step_scaler.sv */
// Clock-direction step scaler: emits mul/div output steps per input pulse
`timescale 1ns/1ps
module cd_step_scaler (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic pulse_in,
  input wire logic [15:0] mul_in,
  input wire logic [15:0] div_in,
  output logic step_out
);

  motor_ctl_pkg::cd_state_s st;
  motor_ctl_pkg::cd_state_s next_st;
  logic [16:0] div_eff;
  logic [16:0] acc_add;

  // A zero divider would never drain, so it acts as one
  assign div_eff = (div_in == 16'h0000) ? 17'h00001 : {1'b0, div_in};

  always_comb
  begin
    next_st = st;
    acc_add = st.acc;
    if (pulse_in && (acc_add <= 17'h1ffff - {1'b0, mul_in}))
    begin
      acc_add = acc_add + {1'b0, mul_in};
    end
    // At most one step per cycle; a large ratio drains over later cycles
    next_st.step = (acc_add >= div_eff); // see R18
    next_st.acc = next_st.step ? acc_add - div_eff : acc_add; // see R18
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st <= '0;
    else if (ce_in)
      st <= next_st;
  end

  assign step_out = st.step;

endmodule : cd_step_scaler

/* File: verif/bus_master_model.sv */
// Fieldbus master model: object writes, reads and the standard setup sequences
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  output motor_ctl_pkg::bus_req_s bus_out
);
  initial
  begin
    bus_out = '0;
  end

  // Released write data is inverted so a stale value is never mistaken for a fresh one
  task automatic wr_obj(input logic [15:0] addr, input logic [31:0] data);
    @(posedge clk_in);
    bus_out.wr <= 1'b1;
    bus_out.addr <= addr;
    bus_out.wdata <= data;
    @(posedge clk_in);
    bus_out.wr <= 1'b0;
    bus_out.wdata <= ~data;
  endtask : wr_obj

  // Read-back after a transfer confirms that the object took the value
  task automatic rd_obj(input logic [15:0] addr, output logic [31:0] data);
    @(posedge clk_in);
    bus_out.rd <= 1'b1;
    bus_out.addr <= addr;
    @(posedge clk_in);
    bus_out.rd <= 1'b0;
    #1;
    data = rdata_in;
  endtask : rd_obj

  // Open loop needs pole pairs, current in mA and the loop-select bit clear
  // Cyclic position and velocity modes are never chosen here for open loop
  task automatic cfg_motor(input logic [7:0] poles, input logic [15:0] ima,
                           input logic [31:0] sub);
    wr_obj(motor_ctl_pkg::OFS_POLES, {24'h000000, poles});
    wr_obj(motor_ctl_pkg::OFS_IMAX, {16'h0000, ima});
    wr_obj(motor_ctl_pkg::OFS_SUBMODE, sub);
  endtask : cfg_motor

  // Mode first, then target, then walk the power states up to operation enabled
  task automatic run_mode(input logic [7:0] mode, input logic [31:0] speed);
    wr_obj(motor_ctl_pkg::OFS_MODE_SEL, {24'h000000, mode});
    wr_obj(motor_ctl_pkg::OFS_TGT_VEL, speed);
    wr_obj(motor_ctl_pkg::OFS_CTRL, 32'h00000006);
    wr_obj(motor_ctl_pkg::OFS_CTRL, 32'h00000007);
    wr_obj(motor_ctl_pkg::OFS_CTRL, 32'h0000000f);
  endtask : run_mode
endmodule : bus_master_model

/* File: verif/open_loop_mode_control_tb.sv */
// Self-checking testbench of the control-mode block
`timescale 1ns/1ps
module open_loop_mode_control_tb;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  motor_ctl_pkg::bus_req_s bus;
  logic [31:0] rdata;
  motor_ctl_pkg::setup_s setup_in = '0;
  logic motion_pin_in = 1'b1;
  logic step_pin_in = 1'b0;
  logic dir_pin_in = 1'b0;
  motor_ctl_pkg::drive_s drive;
  logic [1:0] store;
  logic step;
  logic [31:0] rv;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_steps = 0;

  always #4 clk_in = ~clk_in;

  bus_master_model m (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));

  mode_ctl #(.CYC_PER_MS(10)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .bus_in(bus), .rdata_out(rdata),
    .setup_in(setup_in), .motion_pin_in(motion_pin_in), .step_pin_in(step_pin_in),
    .dir_pin_in(dir_pin_in), .drive_out(drive), .store_out(store), .step_out(step)
  );

  always @(posedge clk_in)
  begin
    if (step === 1'b1)
    begin
      n_steps++;
    end
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #200000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    settle(2);
    // ----------------------------------------
    // Reset values and unmapped space
    // ----------------------------------------
    check("open loop after reset", drive.open_loop, 1'b1);
    check("reset current", drive.cur_ma, 16'h01f4);
    m.rd_obj(motor_ctl_pkg::OFS_POLES, rv);
    check("poles reset", rv, 32'h00000032);
    m.rd_obj(motor_ctl_pkg::OFS_RED_MA, rv);
    check("red reset", rv, 32'h000000fa);
    m.rd_obj(16'h5555, rv);
    check("unmapped", rv, 32'h00000000);
    // ----------------------------------------
    // Loop selection and motor type
    // ----------------------------------------
    m.cfg_motor(8'h64, 16'h04b0, 32'h00000001);
    settle(2);
    check("closed loop", drive.open_loop, 1'b0);
    m.wr_obj(motor_ctl_pkg::OFS_SUBMODE, 32'h00000040);
    settle(2);
    check("brushless closed", drive.open_loop, 1'b0);
    m.wr_obj(motor_ctl_pkg::OFS_FB_CFG, 32'h00000003);
    settle(2);
    check("feedback combined", {drive.fb_phys, drive.fb_model}, 2'b11);
    m.wr_obj(motor_ctl_pkg::OFS_SUBMODE, 32'h00000008);
    settle(2);
    check("open full current", drive.cur_ma, 16'h04b0);
    // ----------------------------------------
    // Standstill reduction after 2 ms idle
    // ----------------------------------------
    m.wr_obj(motor_ctl_pkg::OFS_IDLE_MS, 32'h00000002);
    m.wr_obj(motor_ctl_pkg::OFS_RED_MA, 32'h0000012c);
    @(posedge clk_in);
    motion_pin_in <= 1'b0;
    settle(14);
    check("no early cut", drive.reduced, 1'b0);
    for (int i = 0; i < 40 && drive.reduced !== 1'b1; i++)
      settle(1);
    check("cut active", drive.reduced, 1'b1);
    check("cut current", drive.cur_ma, 16'h012c);
    m.rd_obj(motor_ctl_pkg::OFS_STAT, rv);
    check("status cut bit", rv[9], 1'b1);
    @(posedge clk_in);
    motion_pin_in <= 1'b1;
    settle(5);
    check("motion full current", drive.cur_ma, 16'h04b0);
    // ----------------------------------------
    // Forbidden modes in open loop
    // ----------------------------------------
    // Homing runs last so that it stays the running mode for the block-method checks below
    m.wr_obj(motor_ctl_pkg::OFS_HOME_METH, 32'h000000fe);
    for (int i = 0; i < 3; i++)
    begin
      m.run_mode(i == 0 ? motor_ctl_pkg::MODE_TORQUE : i == 1 ? motor_ctl_pkg::MODE_CST
                 : motor_ctl_pkg::MODE_HOMING, 32'h0);
      settle(3);
      check("mode refused", {drive.enable, drive.mode_fault}, 2'b01);
      m.wr_obj(motor_ctl_pkg::OFS_CTRL, 32'h00000000);
    end
    m.wr_obj(motor_ctl_pkg::OFS_HOME_METH, 32'h000000fe);
    settle(2);
    check("block homing off", drive.homing_ok, 1'b0);
    m.wr_obj(motor_ctl_pkg::OFS_HOME_METH, 32'h00000001);
    settle(2);
    check("other homing on", drive.homing_ok, 1'b1);
    // ----------------------------------------
    // Velocity test run, mode lock and stop
    // ----------------------------------------
    m.run_mode(8'h02, 32'h000000c8);
    settle(3);
    check("enabled", drive.enable, 1'b1);
    check("mode shown", drive.mode_act, 8'h02);
    m.wr_obj(motor_ctl_pkg::OFS_MODE_SEL, 32'h00000001);
    m.rd_obj(motor_ctl_pkg::OFS_MODE_SEL, rv);
    check("mode locked", rv, 32'h00000002);
    m.rd_obj(motor_ctl_pkg::OFS_MODE_ACT, rv);
    check("mode display", rv, 32'h00000002);
    m.wr_obj(motor_ctl_pkg::OFS_CTRL, 32'h00000000);
    settle(3);
    check("stopped", drive.enable, 1'b0);
    m.rd_obj(motor_ctl_pkg::OFS_STAT, rv);
    check("status disabled", rv[6:0], 7'h40);
    // ----------------------------------------
    // Clock-direction scaling 3/2
    // ----------------------------------------
    m.wr_obj(motor_ctl_pkg::OFS_CD_MUL, 32'h00000003);
    m.wr_obj(motor_ctl_pkg::OFS_CD_DIV, 32'h00000002);
    dir_pin_in <= 1'b1;
    n_steps = 0;
    repeat (4)
    begin
      step_pin_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      step_pin_in <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    settle(10);
    check("scaled steps", n_steps, 32'd6);
    check("direction", drive.dir, 1'b1);
    @(posedge clk_in);
    ce_in <= 1'b0;
    m.wr_obj(motor_ctl_pkg::OFS_IMAX, 32'h00000111);
    ce_in <= 1'b1;
    m.rd_obj(motor_ctl_pkg::OFS_IMAX, rv);
    check("frozen by clock enable", rv, 32'h000004b0);
    // ----------------------------------------
    // Auto setup results, store and restart
    // ----------------------------------------
    @(posedge clk_in);
    setup_in <= '{done: 1'b1, ok: 1'b1, poles: 8'h32, res_r: 32'h00000123,
                  res_l: 32'h00000456};
    @(posedge clk_in);
    setup_in.done <= 1'b0;
    #1;
    check("store pulse", store, 2'b11);
    m.rd_obj(motor_ctl_pkg::OFS_RES_L, rv);
    check("setup copy", rv, 32'h00000456);
    m.rd_obj(motor_ctl_pkg::OFS_STAT, rv);
    check("coords invalid", rv[14], 1'b1);
    // The master restarts the device; homing alone would not clear the flag
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    m.rd_obj(motor_ctl_pkg::OFS_STAT, rv);
    check("coords valid", rv[14], 1'b0);
    print_verdict();
  end
endmodule : open_loop_mode_control_tb
